// ==== logic/tos_pkg.sv ====
// Package for the telegram output scheduler: register map, codes, timing.
// Assumes a 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
package tos_pkg;
  // Clock
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int CYC_PER_S = CLK_MHZ * 1000000;
  // Byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INTERVAL = 8'h04;
  localparam logic [7:0] A_UNIT = 8'h08;
  localparam logic [7:0] A_PLAUS = 8'h0c;
  localparam logic [7:0] A_SRCMODE = 8'h10;
  localparam logic [7:0] A_RDELAY = 8'h14;
  localparam logic [7:0] A_RESTART = 8'h18;
  localparam logic [7:0] A_TIME = 8'h1c;
  localparam logic [7:0] A_DATE = 8'h20;
  localparam logic [7:0] A_SLEEP = 8'h24;
  localparam logic [7:0] A_TRIG = 8'h28;
  localparam logic [7:0] A_WARN = 8'h2c;
  localparam logic [7:0] A_AVG = 8'h30;
  localparam logic [7:0] A_SERIAL = 8'h34;
  localparam logic [7:0] A_STATUS = 8'h38;
  localparam logic [7:0] A_CMDDONE = 8'h3c;
  localparam logic [7:0] A_FWLOAD = 8'h40;
  // Control register fields
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_CONFIG_ACCESS_LEVEL = 1;
  localparam int CTRL_FW_START = 2;
  // Ranges and reset values
  localparam logic [13:0] INTERVAL_MIN = 14'd10;
  localparam logic [13:0] INTERVAL_MAX = 14'd10000;
  localparam logic [13:0] INTERVAL_RST = 14'd100;
  localparam logic [1:0] UNIT_MAX = 2'd3;
  localparam logic [1:0] UNIT_RST = 2'd0;
  localparam logic [1:0] PLAUS_MIN = 2'd2;
  localparam logic [1:0] PLAUS_RST = 2'd2;
  localparam logic [2:0] SRC_MAX = 3'd5;
  localparam logic [2:0] SRC_RST = 3'd0;
  localparam logic [9:0] RDELAY_MAX = 10'd1000;
  localparam logic [9:0] RDELAY_RST = 10'd5;
  localparam logic [1:0] RESTART_WARM = 2'd1;
  localparam logic [1:0] RESTART_WDT = 2'd2;
  localparam logic [10:0] SLEEP_MAX = 11'd600;
  localparam logic [10:0] SLEEP_TRIG = 11'd1000;
  localparam logic [2:0] TRIG_MAX = 3'd4;
  localparam int WDT_S = 11;
  localparam int FWLOAD_MIN = 3;
  localparam int SLVERR = 2;
  localparam int OKAY = 0;
  // Trigger codes
  typedef enum logic [2:0] {
    TRG_OFF = 3'd0, TRG_RISE = 3'd1, TRG_FALL = 3'd2, TRG_HIGH = 3'd3, TRG_LOW = 3'd4
  } tos_trig_t;
  // Measured values carried together
  typedef struct packed {
    logic [15:0] speed;
    logic [15:0] dir;
  } tos_meas_t;
endpackage : tos_pkg

// ==== logic/tos_top.sv ====
// Telegram output scheduler: autonomous/triggered telegrams, settings, sleep, watchdog.
// Assumes AXI4-Lite master, synchronous inputs, a serial transmitter with ready.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module tos_top
  import tos_pkg::*;
#(
  parameter int MS_CYC = CYC_PER_MS,
  parameter int S_CYC = CYC_PER_S,
  parameter logic [31:0] SERIAL_NUM = 32'h1234_5678 // Arbitrary value
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurement and telegram stream
  input wire tos_meas_t meas_in,
  input wire logic meas_valid,
  input wire logic tx_ready,
  output logic tx_valid,
  output tos_meas_t tx_data,
  output logic reply_start,
  // Control line and status
  input wire logic ctrl_line,
  input wire logic fault,
  input wire logic [15:0] wind_speed,
  output logic pullup_on,
  output logic proc_clk_en,
  output logic avg_period_used_ms_unused,
  output logic [13:0] avg_period_ms,
  output logic sys_restart
);
  // Settings
  logic [1:0] ctrl_ff;
  logic [13:0] interval_ff;
  logic [1:0] unit_ff;
  logic [1:0] plaus_ff;
  logic [2:0] src_ff;
  logic [9:0] rdelay_ff;
  logic [23:0] time_ff;
  logic [23:0] date_ff;
  logic [10:0] sleep_ff;
  logic [2:0] trig_ff;
  logic [15:0] warn_ff;
  logic [13:0] avg_ff;
  logic wdt_stop_ff;
  logic fw_ff;
  logic warm_ff;
  // Bus state
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go, wr_ok, config_access_level;
  logic [31:0] wd;
  // Scheduler state
  logic [31:0] ms_cnt_ff, s_cnt_ff;
  logic ms_tick, s_tick;
  logic [13:0] iv_cnt_ff;
  logic [10:0] sl_cnt_ff;
  logic ctrl_d_ff;
  logic trig_hit, due;
  tos_meas_t latest_ff;
  logic tx_valid_ff;
  tos_meas_t tx_data_ff;
  logic [15:0] drop_ff;
  logic alarm_ff;
  logic [9:0] rd_cnt_ff;
  logic rd_busy_ff;
  logic reply_ff;
  logic [7:0] wdt_cnt_ff;
  logic [7:0] fw_cnt_ff;
  logic sleep_meas_ff;

  // BCD check on a two-digit field; used for time and date
  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] max);
    bcd_ok = (v[3:0] <= 4'd9) && (v[7:4] <= 4'd9) && (v <= max);
  endfunction : bcd_ok

  assign config_access_level = ctrl_ff[CTRL_CONFIG_ACCESS_LEVEL];
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_go = aw_ff && w_ff && !bvalid_ff;
  assign wd = wdata_ff;

  // Write address and data capture in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
      end
    end
  end

  // Write legality: config_access_level gate and range checks
  always_comb
  begin
    wr_ok = 1'b0;
    case (awaddr_ff)
      A_CTRL: wr_ok = 1'b1;
      A_INTERVAL: wr_ok = config_access_level && (wd[13:0] == 14'd0 || (wd[13:0] >= INTERVAL_MIN
        && wd[13:0] <= INTERVAL_MAX)) && wd[31:14] == 18'd0;
      A_UNIT: wr_ok = config_access_level && wd[31:2] == 30'd0;
      A_PLAUS: wr_ok = config_access_level && wd[31:2] == 30'd0 && wd[1:0] >= PLAUS_MIN;
      A_SRCMODE: wr_ok = config_access_level && wd[31:3] == 29'd0 && wd[2:0] <= SRC_MAX;
      A_RDELAY: wr_ok = config_access_level && wd[31:10] == 22'd0 && wd[9:0] <= RDELAY_MAX;
      A_RESTART: wr_ok = config_access_level && (wd == 32'd1 || wd == 32'd2);
      A_TIME: wr_ok = config_access_level && wd[31:24] == 8'd0 && bcd_ok(wd[23:16], 8'h23)
        && bcd_ok(wd[15:8], 8'h59) && bcd_ok(wd[7:0], 8'h59);
      A_DATE: wr_ok = config_access_level && wd[31:24] == 8'd0 && bcd_ok(wd[23:16], 8'h31)
        && wd[23:16] != 8'h00 && bcd_ok(wd[15:8], 8'h12) && wd[15:8] != 8'h00
        && bcd_ok(wd[7:0], 8'h99);
      A_SLEEP: wr_ok = config_access_level && (wd[31:0] <= 32'(SLEEP_MAX) || wd == 32'(SLEEP_TRIG));
      A_TRIG: wr_ok = config_access_level && wd[31:3] == 29'd0 && wd[2:0] <= TRIG_MAX;
      A_WARN: wr_ok = config_access_level && wd[31:16] == 16'd0;
      A_AVG: wr_ok = config_access_level && wd[31:14] == 18'd0;
      A_CMDDONE: wr_ok = 1'b1;
      A_FWLOAD: wr_ok = config_access_level;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write response; refused writes answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'(OKAY);
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? 2'(OKAY) : 2'(SLVERR);
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // Setting registers; warm restart reloads power-up values
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      ctrl_ff <= 2'b00;
      interval_ff <= INTERVAL_RST;
      unit_ff <= UNIT_RST;
      plaus_ff <= PLAUS_RST;
      src_ff <= SRC_RST;
      rdelay_ff <= RDELAY_RST;
      sleep_ff <= 11'd0;
      trig_ff <= 3'd0;
      warn_ff <= 16'h0000;
      avg_ff <= 14'd0;
    end
    else if (wr_go && wr_ok)
    begin
      case (awaddr_ff)
        A_CTRL: ctrl_ff <= wd[1:0];
        A_INTERVAL: interval_ff <= wd[13:0];
        A_UNIT: unit_ff <= wd[1:0];
        A_PLAUS: plaus_ff <= wd[1:0];
        A_SRCMODE: src_ff <= wd[2:0];
        A_RDELAY: rdelay_ff <= wd[9:0];
        A_SLEEP: sleep_ff <= wd[10:0];
        A_TRIG: trig_ff <= wd[2:0];
        A_WARN: warn_ff <= wd[15:0];
        A_AVG: avg_ff <= wd[13:0];
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Restart commands and firmware-load entry
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      warm_ff <= 1'b0;
      wdt_stop_ff <= 1'b0;
      fw_ff <= 1'b0;
    end
    else
    begin
      if (wr_go && wr_ok && awaddr_ff == A_RESTART)
      begin
        warm_ff <= (wd[1:0] == RESTART_WARM);
        wdt_stop_ff <= (wd[1:0] == RESTART_WDT);
      end
      if (wr_go && wr_ok && awaddr_ff == A_FWLOAD)
        fw_ff <= 1'b1;
      if (wr_go && wr_ok && awaddr_ff == A_CTRL && wd[CTRL_FW_START])
        fw_ff <= 1'b0; // Upload began; timeout cancelled
      if ((wdt_stop_ff && wdt_cnt_ff == 8'(WDT_S)) ||
          (fw_ff && fw_cnt_ff == 8'(FWLOAD_MIN * 60)))
        warm_ff <= 1'b1;
    end
  end

  // Watchdog and firmware-load timeouts in seconds
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      wdt_cnt_ff <= 8'd0;
      fw_cnt_ff <= 8'd0;
    end
    else if (s_tick)
    begin
      if (wdt_stop_ff)
        wdt_cnt_ff <= wdt_cnt_ff + 8'd1;
      if (fw_ff)
        fw_cnt_ff <= fw_cnt_ff + 8'd1;
    end
  end
  assign sys_restart = warm_ff;

  // Clock/calendar held exactly as written; no daylight-saving logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      time_ff <= 24'h000000;
      date_ff <= 24'h010100;
    end
    else if (wr_go && wr_ok && awaddr_ff == A_TIME)
      time_ff <= wd[23:0];
    else if (wr_go && wr_ok && awaddr_ff == A_DATE)
      date_ff <= wd[23:0];
  end

  // Read path; serial needs no access key
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'(OKAY);
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= 2'(OKAY);
      case (s_axi_araddr)
        A_CTRL: rdata_ff <= {30'd0, ctrl_ff};
        A_INTERVAL: rdata_ff <= {18'd0, interval_ff};
        A_UNIT: rdata_ff <= {30'd0, unit_ff};
        A_PLAUS: rdata_ff <= {30'd0, plaus_ff};
        A_SRCMODE: rdata_ff <= {29'd0, src_ff};
        A_RDELAY: rdata_ff <= {22'd0, rdelay_ff};
        A_TIME: rdata_ff <= {8'd0, time_ff};
        A_DATE: rdata_ff <= {8'd0, date_ff};
        A_SLEEP: rdata_ff <= {21'd0, sleep_ff};
        A_TRIG: rdata_ff <= {29'd0, trig_ff};
        A_WARN: rdata_ff <= {16'd0, warn_ff};
        A_AVG: rdata_ff <= {18'd0, avg_ff};
        A_SERIAL: rdata_ff <= SERIAL_NUM;
        A_STATUS: rdata_ff <= {drop_ff, 12'd0, fw_ff, wdt_stop_ff, alarm_ff, rd_busy_ff};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= 2'(SLVERR);
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // Millisecond and second tick dividers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms_cnt_ff <= 32'd0;
      s_cnt_ff <= 32'd0;
    end
    else
    begin
      ms_cnt_ff <= ms_tick ? 32'd0 : ms_cnt_ff + 32'd1;
      s_cnt_ff <= s_tick ? 32'd0 : s_cnt_ff + 32'd1;
    end
  end
  assign ms_tick = (ms_cnt_ff == 32'(MS_CYC - 1));
  assign s_tick = (s_cnt_ff == 32'(S_CYC - 1));

  // Interval and sleep-wake timers
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff || (wr_go && wr_ok && awaddr_ff == A_INTERVAL))
      iv_cnt_ff <= 14'd0;
    else if (ms_tick)
      iv_cnt_ff <= (iv_cnt_ff + 14'd1 >= interval_ff) ? 14'd0 : iv_cnt_ff + 14'd1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff || sleep_ff == 11'd0 || sleep_ff == SLEEP_TRIG)
      sl_cnt_ff <= 11'd0;
    else if (s_tick)
      sl_cnt_ff <= (sl_cnt_ff + 11'd1 >= sleep_ff) ? 11'd0 : sl_cnt_ff + 11'd1;
  end

  // Trigger detection on the control line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_d_ff <= 1'b0;
    else
      ctrl_d_ff <= ctrl_line;
  end
  always_comb
  begin
    case (tos_trig_t'(trig_ff))
      TRG_RISE: trig_hit = ctrl_line && !ctrl_d_ff;
      TRG_FALL: trig_hit = !ctrl_line && ctrl_d_ff;
      TRG_HIGH: trig_hit = ctrl_line && ms_tick;
      TRG_LOW: trig_hit = !ctrl_line && ms_tick;
      default: trig_hit = 1'b0;
    endcase
  end

  // Telegram due: sleep timer, else trigger when interval zero or sleep 1000, else timer when interval nonzero and auto set
  always_comb
  begin
    if (sleep_ff != 11'd0 && sleep_ff != SLEEP_TRIG)
      due = s_tick && (sl_cnt_ff + 11'd1 >= sleep_ff);
    else if (sleep_ff == SLEEP_TRIG || interval_ff == 14'd0)
      due = trig_hit;
    else
      due = ctrl_ff[CTRL_AUTO] && ms_tick && (iv_cnt_ff + 14'd1 >= interval_ff);
  end

  // Latest measurement kept and repeated in every telegram
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      latest_ff <= '0;
    else if (meas_valid)
      latest_ff <= meas_in;
  end

  // Telegram handoff; a due telegram while busy is dropped and counted
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= '0;
      drop_ff <= 16'd0;
    end
    else
    begin
      if (tx_valid_ff && tx_ready)
        tx_valid_ff <= 1'b0;
      if (due && (tx_valid_ff || !tx_ready))
        drop_ff <= drop_ff + 16'd1;
      else if (due)
      begin
        tx_valid_ff <= 1'b1;
        tx_data_ff <= latest_ff;
      end
    end
  end
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;

  // Response delay after a command ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
    begin
      rd_busy_ff <= 1'b0;
      rd_cnt_ff <= 10'd0;
      reply_ff <= 1'b0;
    end
    else
    begin
      reply_ff <= 1'b0;
      if (wr_go && wr_ok && awaddr_ff == A_CMDDONE)
      begin
        rd_busy_ff <= 1'b1;
        rd_cnt_ff <= 10'd0;
      end
      else if (rd_busy_ff && (rd_cnt_ff >= rdelay_ff))
      begin
        rd_busy_ff <= 1'b0;
        reply_ff <= 1'b1;
      end
      else if (rd_busy_ff && ms_tick)
        rd_cnt_ff <= rd_cnt_ff + 10'd1;
    end
  end
  assign reply_start = reply_ff;

  // Wind alarm hysteresis, thresholds in 0.1 m/s, upper in high byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warm_ff)
      alarm_ff <= 1'b0;
    else if (wind_speed > {8'd0, warn_ff[15:8]})
      alarm_ff <= 1'b1;
    else if (wind_speed < {8'd0, warn_ff[7:0]})
      alarm_ff <= 1'b0;
  end

  // Sleep: processor clock only runs around a measurement
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sleep_meas_ff <= 1'b0;
    else
      sleep_meas_ff <= due || meas_valid;
  end
  assign proc_clk_en = (sleep_ff == 11'd0) || sleep_meas_ff || due;

  // Pull-up source by mode, always off in sleep
  always_comb
  begin
    case (src_ff)
      3'd1: pullup_on = 1'b1;
      3'd2: pullup_on = alarm_ff;
      3'd3: pullup_on = !alarm_ff;
      3'd4: pullup_on = fault;
      3'd5: pullup_on = !fault;
      default: pullup_on = 1'b0;
    endcase
    if (sleep_ff != 11'd0)
      pullup_on = 1'b0;
  end

  // Averaging period falls back to the output interval
  assign avg_period_ms = (avg_ff == 14'd0) ? interval_ff : avg_ff;
  assign avg_period_used_ms_unused = (avg_ff == 14'd0);

  // Checks
  AST_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    due && (tx_valid_ff || !tx_ready) && !warm_ff |=> drop_ff == $past(drop_ff) + 16'd1)
    else $error("busy telegram not dropped");
  AST_NOADMIN: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !config_access_level && awaddr_ff == A_UNIT && !warm_ff |=> $stable(unit_ff))
    else $error("write accepted without access");
  AST_SLEEP_PU: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_ff != 11'd0 |-> !pullup_on) else $error("pull-up in sleep");
  AST_AVG: assert property (@(posedge aclk) disable iff (!aresetn)
    avg_ff == 14'd0 |-> avg_period_ms == interval_ff) else $error("avg fallback");
  AST_TRIGONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    interval_ff == 14'd0 && sleep_ff == 11'd0 && trig_ff == 3'd0 |-> !due)
    else $error("timer telegram with zero interval");
  // Between the thresholds a set alarm must stay set
  AST_ALARM_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    alarm_ff && wind_speed >= {8'd0, warn_ff[7:0]} && !warm_ff |=> alarm_ff)
    else $error("wind alarm cleared inside hysteresis");
endmodule : tos_top

// ==== tb/tos_host_model.sv ====
// Host-side telegram receiver for the scheduler bench.
// Assumes tx_valid holds until taken; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module tos_host_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pacing chosen by the bench
  input wire logic slow,
  // Telegram stream
  input wire logic tx_valid,
  output logic tx_ready,
  output int n_rx_ff
);
  int busy_ff;
  // A slow host stays busy after each telegram, like a line still shifting bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_ff <= 0;
      n_rx_ff <= 0;
    end
    else if (tx_valid && tx_ready)
    begin
      n_rx_ff <= n_rx_ff + 1;
      busy_ff <= slow ? 300 : 0;
    end
    else if (busy_ff > 0)
      busy_ff <= busy_ff - 1;
  end
  // Ready only when idle
  assign tx_ready = aresetn && (busy_ff == 0);
endmodule : tos_host_model

// ==== tb/telegram_output_scheduler_test.sv ====
// Self-checking bench for the telegram output scheduler.
// Assumes MS_CYC 10 and S_CYC 100 so that long timers fit a short run.
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
  end
module telegram_output_scheduler_test;
  import tos_pkg::*;
  localparam logic [31:0] SER = 32'h0bad_cafe; // Arbitrary value
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic meas_valid, tx_ready, tx_valid, reply_start, ctrl_line, fault, pullup_on;
  logic proc_clk_en, avg_period_used_ms_unused, sys_restart, slow, config_access_level, f;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, m;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] wind_speed;
  logic [13:0] avg_period_ms;
  tos_meas_t meas_in, tx_data;
  logic [31:0] mdl [logic [7:0]];
  int failures, n_compared, cyc, n_rx, n0, n, i;

  tos_top #(.MS_CYC(10), .S_CYC(100), .SERIAL_NUM(SER)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .meas_in(meas_in), .meas_valid(meas_valid),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .reply_start(reply_start), .ctrl_line(ctrl_line), .fault(fault),
    .wind_speed(wind_speed), .pullup_on(pullup_on), .proc_clk_en(proc_clk_en),
    .avg_period_used_ms_unused(avg_period_used_ms_unused),
    .avg_period_ms(avg_period_ms), .sys_restart(sys_restart));
  tos_host_model u_host (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .n_rx_ff(n_rx));

  // Clock, 100 MHz
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard well above the expected run length
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      results();
    end
  end

  task automatic results;
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // Power-up settings as the model expects them
  function automatic void mdl_reset;
    mdl.delete();
    mdl[A_INTERVAL] = 100;
    mdl[A_UNIT] = 0;
    mdl[A_PLAUS] = 2;
    mdl[A_SRCMODE] = 0;
    mdl[A_RDELAY] = 5;
    config_access_level = 1'b0;
  endfunction : mdl_reset

  // Model of which writes are accepted
  function automatic logic ok_wr(input logic [7:0] a, input int d);
    if (!config_access_level && a != A_CTRL)
      return 1'b0;
    case (a)
      A_INTERVAL: return d == 0 || (d >= 10 && d <= 10000);
      A_UNIT: return d <= 3;
      A_PLAUS: return d == 2 || d == 3;
      A_SRCMODE: return d <= 5;
      A_RDELAY: return d <= 1000;
      A_TRIG: return d <= 4;
      A_SLEEP: return d <= 600 || d == 1000;
      default: return 1'b1;
    endcase
  endfunction : ok_wr

  // Handshakes are judged at the falling edge, where the next rising edge's values stand
  task automatic wr(input logic [7:0] a, input int d);
    logic ha, hw, hb, ok;
    logic [1:0] r;
    @(posedge aclk); // Start off a rising edge, never in the step of the last release
    ok = ok_wr(a, d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 50 && !hb; n++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", ok ? 2'd0 : 2'd2, r)
    if (ok && a == A_CTRL)
      config_access_level = d[CTRL_CONFIG_ACCESS_LEVEL];
    else if (ok)
      mdl[a] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ha, hb;
    logic [1:0] r;
    @(posedge aclk); // Start off a rising edge, never in the step of the last release
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 50 && !hb; n++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hb = s_axi_rvalid && s_axi_rready;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ha)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, r)
  endtask : rd

  task automatic rdm(input logic [7:0] a);
    rd(a, 2'd0, v);
    `CHK("rdata", mdl[a], v)
  endtask : rdm

  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, meas_valid, ctrl_line, slow} = '0;
    s_axi_wstrb = 4'hf;
    wind_speed = 16'h0;
    meas_in = '0;
    f = $urandom(32'h3312);
    fault = $urandom;
    f = fault;
    mdl_reset();
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (mdl[k]) rdm(k);
    rd(A_SERIAL, 2'd0, v);
    `CHK("serial", SER, v)
    rd(8'hfc, 2'd2, v);
    wr(A_UNIT, 1);
    wr(A_CTRL, 2);
    wr(A_INTERVAL, 5);
    wr(A_INTERVAL, 10001);
    wr(A_PLAUS, 1);
    wr(A_SRCMODE, 6);
    wr(A_RDELAY, 1001);
    wr(A_SLEEP, 601);
    for (i = 0; i < 5; i++) wr(A_UNIT, i);
    rdm(A_UNIT);
    wr(A_PLAUS, 3);
    rdm(A_PLAUS);
    for (i = 0; i < 6; i++)
    begin
      wr(A_SRCMODE, i);
      `CHK("pullup", i == 1 || i == 3 || (i == 4 && f) || (i == 5 && !f), pullup_on)
    end
    // Warning hysteresis, upper 50 and lower 20
    wr(A_WARN, 32'h3214);
    wr(A_SRCMODE, 2);
    wind_speed <= 16'd60;
    repeat (5) @(posedge aclk);
    `CHK("warn set", 1'b1, pullup_on)
    wind_speed <= 16'd30;
    repeat (5) @(posedge aclk);
    `CHK("warn hold", 1'b1, pullup_on)
    wind_speed <= 16'd10;
    repeat (5) @(posedge aclk);
    `CHK("warn clear", 1'b0, pullup_on)
    // Autonomous output, one measurement repeated
    m = $urandom;
    meas_in <= m;
    meas_valid <= 1'b1;
    @(posedge aclk);
    meas_valid <= 1'b0;
    wr(A_AVG, 0);
    wr(A_CTRL, 3);
    wr(A_INTERVAL, 10);
    n0 = n_rx;
    repeat (1000) @(posedge aclk);
    `CHK("telegrams", 1'b1, (n_rx - n0) inside {[9:10]})
    `CHK("tx_data", m, tx_data)
    `CHK("avg", 14'd10, avg_period_ms)
    `CHK("avg fallback", 1'b1, avg_period_used_ms_unused)
    slow <= 1'b1;
    repeat (1000) @(posedge aclk);
    rd(A_STATUS, 2'd0, v);
    `CHK("drops", 1'b1, v[31:16] != 16'h0)
    slow <= 1'b0;
    wr(A_INTERVAL, 0);
    n0 = n_rx;
    repeat (500) @(posedge aclk);
    `CHK("no timer", 0, n_rx - n0)
    for (i = 1; i <= 4; i++)
    begin
      ctrl_line <= (i == 2 || i == 4);
      repeat (30) @(posedge aclk);
      wr(A_TRIG, i);
      n0 = n_rx;
      ctrl_line <= !(i == 2 || i == 4);
      repeat (100) @(posedge aclk);
      `CHK("trigger", 1'b1, i <= 2 ? n_rx - n0 == 1 : n_rx - n0 >= 5)
    end
    wr(A_TRIG, 0);
    wr(A_TIME, 32'h120000);
    rdm(A_TIME);
    wr(A_DATE, 32'h310708);
    rdm(A_DATE);
    wr(A_RDELAY, 20);
    wr(A_CMDDONE, 1);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (reply_start !== 1'b1 && n < 400);
    `CHK("reply delay", 1'b1, n >= 190 && n <= 210)
    // Sleep in trigger-wake mode, no trigger set: pull-up and processor clock off
    wr(A_SRCMODE, 1);
    wr(A_SLEEP, 1000);
    repeat (5) @(posedge aclk);
    `CHK("sleep pullup", 1'b0, pullup_on)
    `CHK("sleep clock", 1'b0, proc_clk_en)
    // Timed wake every 2 s; second tick phase allows one telegram fewer
    wr(A_SLEEP, 2);
    n0 = n_rx;
    repeat (1000) @(posedge aclk);
    `CHK("timed wake", 1'b1, (n_rx - n0) inside {[4:5]})
    wr(A_SLEEP, 0);
    wr(A_RESTART, 1);
    repeat (20) @(posedge aclk);
    mdl_reset();
    foreach (mdl[k]) rdm(k);
    wr(A_CTRL, 2);
    wr(A_RESTART, 2);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (sys_restart !== 1'b1 && n < 1300);
    // The free-running second divider puts the first tick anywhere in the first second
    `CHK("watchdog", 1'b1, n >= 1000 && n <= 1110)
    // Upload entry with no upload start restarts after 180 s ticks
    repeat (20) @(posedge aclk);
    wr(A_CTRL, 2);
    wr(A_FWLOAD, 1);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (sys_restart !== 1'b1 && n < 18100);
    `CHK("upload timeout", 1'b1, n >= 17900 && n <= 18010)
    results();
  end
endmodule : telegram_output_scheduler_test
